// ### src/msi_status.sv
/*
 * mac status and interrupt logic: receive interrupt status with
 * enables and a summary bit, the general status register (no
 * interrupt), a small command register and the receive interrupt.
 * assumes the transmit and receive engines run on sys_clk and give
 * one-cycle event pulses and same-clock levels.
 */
// Local design decision: the address-and-strobe port.
// How it works
// - failed crc sets crc error bit
// - summary is or of enabled bits 1-14
// - interrupt when summary and its enable high
// - general status bits never raise interrupts
// - write one clears, zero leaves bit
// - clearing tx on sets tx halted flag
// - sqe flag set only when enabled, 10M half
// - pause frame received or requested sets pause
// - collision count wraps on sixteen, abort set
// - clearing rx on sets rx halted flag
// - four packets in fifo set full flag
module msi_status
   import msi_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic [31:0] regAddr, // register byte address
   input wire logic [31:0] regWrData, // register write data
   input wire logic regWr, // write strobe
   input wire logic regRd, // read strobe
   output logic [31:0] regRdData, // read data, cycle after strobe
   input wire logic crcFail, // pulse: frame failed crc
   input wire logic [14:2] rxEvents, // pulses: other rx events
   input wire logic sqeSeen, // pulse: sqe found at tx end
   input wire logic link10M, // level: link at 10 mbps
   input wire logic halfDuplex, // level: half duplex
   input wire logic pauseFrameRcvd, // pulse: pause frame received
   input wire logic deferred, // pulse: transmission deferred
   input wire logic txStart, // pulse: new transmission begins
   input wire logic collision, // pulse: collision seen
   input wire logic [2:0] rxFifoPackets, // packets held in rx fifo
   input wire logic flowFrameRcvd, // pulse: flow control frame
   output logic rxIrq, // level: receive interrupt
   output logic txHold, // level: hold off normal tx
   output logic rxHold, // level: hold off normal rx
   output logic rxDrop, // level: drop incoming packets
   output logic txAbort, // pulse: tx aborted on collisions
   output logic sendPauseFrame, // pulse: transmit a pause frame
   output logic sqeCheckEn // level: sqe check enabled
);

   // ********************************************************
   // state
   // ********************************************************
   logic [14:1] intStatus_r;
   logic [14:1] intStatus_nxt;
   logic [14:0] intEnable_r;
   logic [31:0] command_r;
   logic rxSummary_r;
   logic [3:0] collCount_r;
   logic [3:0] collCount_nxt;
   logic [11:0] flagSet;
   logic [11:0] flags;
   logic [31:0] genStatus;
   logic [31:0] rdMux;
   logic [14:1] rxSet;
   logic wrIntStatus;
   logic wrIntEnable;
   logic wrCommand;
   logic wrGenStatus;
   logic txOnClear;
   logic rxOnClear;
   logic pauseReq;
   logic sqeCheckEn_r;

   // ********************************************************
   // write decode
   // ********************************************************
   assign wrIntStatus = regWr && (regAddr == ADDR_INT_STATUS);
   assign wrIntEnable = regWr && (regAddr == ADDR_INT_ENABLE);
   assign wrCommand = regWr && (regAddr == ADDR_COMMAND);
   assign wrGenStatus = regWr && (regAddr == ADDR_GEN_STATUS);

   // on-control bits turned off by software
   assign txOnClear = wrCommand && command_r[BIT_TX_ON]
      && !regWrData[BIT_TX_ON];
   assign rxOnClear = wrCommand && command_r[BIT_RX_ON]
      && !regWrData[BIT_RX_ON];
   assign pauseReq = wrCommand && regWrData[BIT_SEND_PAUSE];

   // ********************************************************
   // receive interrupt status
   // ********************************************************
   // only a failed check sets the crc bit; a pass sets nothing
   assign rxSet = {rxEvents, crcFail};

   always_comb
   begin
      intStatus_nxt = intStatus_r;
      if (wrIntStatus)
      begin
         intStatus_nxt = intStatus_nxt & ~regWrData[14:1];
      end
      // set after clear so an event in the clear cycle survives
      intStatus_nxt = intStatus_nxt | rxSet;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         intStatus_r <= RST_REG[14:1];
      end
      else
      begin
         intStatus_r <= intStatus_nxt;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         intEnable_r <= RST_REG[14:0];
      end
      else if (wrIntEnable)
      begin
         intEnable_r <= regWrData[14:0];
      end
   end

   // summary follows the next status so clears drop it at once
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rxSummary_r <= 1'b0;
      end
      else
      begin
         rxSummary_r <= |(intStatus_nxt & intEnable_r[14:1]);
      end
   end

   // interrupt output; general status is never part of it
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rxIrq <= 1'b0;
      end
      else
      begin
         rxIrq <= (|(intStatus_nxt & intEnable_r[14:1]))
            && intEnable_r[BIT_RX_SUMMARY];
      end
   end

   // ********************************************************
   // command register
   // ********************************************************
   // send-pause reads back as zero; it only fires a request
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         command_r <= RST_REG;
      end
      else if (wrCommand)
      begin
         command_r <= regWrData & ~(32'h1 << BIT_SEND_PAUSE);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sendPauseFrame <= 1'b0;
         sqeCheckEn_r <= 1'b0;
      end
      else
      begin
         sendPauseFrame <= pauseReq;
         sqeCheckEn_r <= command_r[BIT_SQE_CHECK_EN];
      end
   end

   assign sqeCheckEn = sqeCheckEn_r;

   // ********************************************************
   // general status flags, set wins over write-one clear
   // ********************************************************
   // set sources by bit position; count and reserved bits stay zero
   always_comb
   begin
      flagSet = 12'h000;
      flagSet[BIT_TX_HALTED] = txOnClear;
      // check runs only with enable set on a 10M half-duplex link
      flagSet[BIT_SQE] = sqeSeen && command_r[BIT_SQE_CHECK_EN]
         && link10M && halfDuplex;
      flagSet[BIT_PAUSED] = pauseFrameRcvd || pauseReq;
      // deferral only counts in half duplex, flow frames in full
      flagSet[BIT_DEFERRED] = deferred && halfDuplex;
      flagSet[BIT_RX_FIFO_FULL] = (rxFifoPackets
         >= RX_FIFO_FULL_PKTS);
      flagSet[BIT_RX_HALTED] = rxOnClear;
      flagSet[BIT_FLOW_FRAME] = flowFrameRcvd && !halfDuplex;
   end

   // bits 7:3 hold the count and a reserved bit, so no flag there
   for (genvar i = 0; i <= BIT_TX_HALTED; i++)
   begin : g_flag
      if (i > BIT_RX_FIFO_FULL && i < BIT_DEFERRED)
      begin : g_none
         assign flags[i] = 1'b0;
      end
      else
      begin : g_sticky
         logic bit_r;
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst)
            begin
               bit_r <= 1'b0;
            end
            else if (flagSet[i])
            begin
               bit_r <= 1'b1;
            end
            else if (wrGenStatus && regWrData[i])
            begin
               bit_r <= 1'b0;
            end
         end
         assign flags[i] = bit_r;
      end
   end

   // ********************************************************
   // collision count
   // ********************************************************
   // four bits wrap naturally: the sixteenth collision reads zero
   always_comb
   begin
      collCount_nxt = collCount_r;
      if (txStart)
      begin
         collCount_nxt = COLLISION_COUNT_RESET;
      end
      else if (wrGenStatus)
      begin
         collCount_nxt = collCount_r & ~regWrData[COLLISION_COUNT_HI:COLLISION_COUNT_LO];
      end
      if (collision)
      begin
         collCount_nxt = collCount_nxt + 4'h1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         collCount_r <= COLLISION_COUNT_RESET;
         txAbort <= 1'b0;
      end
      else
      begin
         collCount_r <= collCount_nxt;
         txAbort <= collision && (collCount_nxt == COLLISION_COUNT_RESET);
      end
   end

   // ********************************************************
   // hold-off outputs to the engines
   // ********************************************************
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         txHold <= 1'b0;
         rxHold <= 1'b0;
         rxDrop <= 1'b0;
      end
      else
      begin
         txHold <= flags[BIT_TX_HALTED] || flags[BIT_PAUSED];
         rxHold <= flags[BIT_RX_HALTED];
         rxDrop <= flags[BIT_RX_FIFO_FULL];
      end
   end

   // ********************************************************
   // read path
   // ********************************************************
   always_comb
   begin
      genStatus = RST_REG;
      genStatus[BIT_TX_HALTED:0] = flags;
      genStatus[COLLISION_COUNT_HI:COLLISION_COUNT_LO] = collCount_r;
   end

   // unmapped addresses read as zero
   always_comb
   begin
      rdMux = RST_REG;
      case (regAddr)
         ADDR_INT_STATUS:
         begin
            rdMux[14:1] = intStatus_r;
            rdMux[BIT_RX_SUMMARY] = rxSummary_r;
         end
         ADDR_INT_ENABLE:
         begin
            rdMux[14:0] = intEnable_r;
         end
         ADDR_COMMAND:
         begin
            rdMux = command_r;
         end
         ADDR_GEN_STATUS:
         begin
            rdMux = genStatus;
         end
         default:
         begin
            rdMux = RST_REG;
         end
      endcase
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         regRdData <= RST_REG;
      end
      else if (regRd)
      begin
         regRdData <= rdMux;
      end
      else
      begin
         regRdData <= RST_REG;
      end
   end

endmodule // msi_status

// ### src/msi_pkg.sv
/*
 * shared constants for the mac status and interrupt block: register
 * byte addresses, field positions, reset values and counts.
 * assumes a 32-bit register port, one clock, synchronous reset.
 */
package msi_pkg;

   // ********************************************************
   // register byte addresses
   // ********************************************************
   localparam logic [31:0] ADDR_INT_STATUS = 32'hb0003080;
   localparam logic [31:0] ADDR_INT_ENABLE = 32'hb0003084;
   localparam logic [31:0] ADDR_COMMAND = 32'hb0003088;
   localparam logic [31:0] ADDR_GEN_STATUS = 32'hb00030b4;

   // ********************************************************
   // interrupt status / enable layout
   // ********************************************************
   localparam int BIT_RX_SUMMARY = 0;
   localparam int BIT_CRC_ERROR = 1;
   localparam int RX_EVT_LO = 1;
   localparam int RX_EVT_HI = 14;

   // ********************************************************
   // general status layout
   // ********************************************************
   localparam int BIT_TX_HALTED = 11;
   localparam int BIT_SQE = 10;
   localparam int BIT_PAUSED = 9;
   localparam int BIT_DEFERRED = 8;
   localparam int COLLISION_COUNT_HI = 7;
   localparam int COLLISION_COUNT_LO = 4;
   localparam int BIT_RX_FIFO_FULL = 2;
   localparam int BIT_RX_HALTED = 1;
   localparam int BIT_FLOW_FRAME = 0;

   // ********************************************************
   // command register layout
   // ********************************************************
   localparam int BIT_RX_ON = 0;
   localparam int BIT_TX_ON = 8;
   localparam int BIT_SQE_CHECK_EN = 17;
   localparam int BIT_SEND_PAUSE = 16;

   // ********************************************************
   // reset values and counts
   // ********************************************************
   localparam logic [31:0] RST_REG = 32'h00000000;
   localparam logic [3:0] COLLISION_COUNT_RESET = 4'h0;
   localparam logic [2:0] RX_FIFO_FULL_PKTS = 3'h4;

endpackage : msi_pkg

// ### testbench/msi_status_asserts.sv
/* port-level checks for msi_status.
   assumes a bind to msi_status, one clock, synchronous reset. */
module msi_status_asserts
   import msi_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic sys_rst, // reset
   input wire logic [31:0] regAddr, // address
   input wire logic [31:0] regWrData, // write data
   input wire logic regWr, // write strobe
   input wire logic regRd, // read strobe
   input wire logic [31:0] regRdData, // read data
   input wire logic crcFail, // crc event
   input wire logic [14:2] rxEvents, // rx events
   input wire logic pauseFrameRcvd, // pause event
   input wire logic collision, // collision event
   input wire logic [2:0] rxFifoPackets, // fifo level
   input wire logic rxIrq, // interrupt
   input wire logic txHold, // tx hold
   input wire logic rxHold, // rx hold
   input wire logic rxDrop, // rx drop
   input wire logic txAbort, // abort pulse
   input wire logic sendPauseFrame, // pause send pulse
   input wire logic sqeCheckEn // sqe check enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic irqCause;
   logic txCause;
   logic cmdWr;
   // outputs may lag their cause by up to two registers
   assign irqCause = crcFail | (|rxEvents) | regWr;
   assign txCause = regWr | pauseFrameRcvd;
   assign cmdWr = regWr && regAddr == ADDR_COMMAND;

   a_rd_data_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
      else $error("read data not zero outside read cycle");
   a_gen_reserved_zero: assert property
      ($past(regRd) && $past(regAddr) == ADDR_GEN_STATUS
       |-> regRdData[31:12] == 20'h0 && !regRdData[3])
      else $error("reserved general status bits not zero");
   a_irq_has_cause: assert property
      ($rose(rxIrq) |-> $past(irqCause, 1) || $past(irqCause, 2))
      else $error("interrupt rose without rx event or write");
   a_abort_after_coll: assert property (txAbort |-> $past(collision))
      else $error("abort without collision");
   a_abort_one_pulse: assert property (txAbort |=> !txAbort)
      else $error("abort longer than one cycle");
   a_drop_when_full: assert property
      (rxFifoPackets >= RX_FIFO_FULL_PKTS |-> ##[1:2] rxDrop)
      else $error("drop not raised with fifo full");
   a_txhold_cause: assert property
      ($rose(txHold) |-> $past(txCause, 1) || $past(txCause, 2)
       || $past(txCause, 3))
      else $error("tx hold rose without cause");
   a_rxhold_cause: assert property
      ($rose(rxHold) |-> $past(regWr, 1) || $past(regWr, 2)
       || $past(regWr, 3))
      else $error("rx hold rose without write");
   a_pause_send_cmd: assert property
      (sendPauseFrame |-> $past(cmdWr) && $past(regWrData[BIT_SEND_PAUSE]))
      else $error("pause frame sent without request");
   a_sqe_en_cmd: assert property
      ($changed(sqeCheckEn) |-> $past(cmdWr, 1) || $past(cmdWr, 2))
      else $error("sqe check enable changed without write");
endmodule // msi_status_asserts

bind msi_status msi_status_asserts u_chk (.sys_clk, .sys_rst, .regAddr,
   .regWrData, .regWr, .regRd, .regRdData, .crcFail, .rxEvents,
   .pauseFrameRcvd, .collision, .rxFifoPackets, .rxIrq, .txHold, .rxHold,
   .rxDrop, .txAbort, .sendPauseFrame, .sqeCheckEn);

// ### testbench/tb.sv
/* directed bench for msi_status through its register port.
   assumes msi_pkg and the bound checker are compiled first. */
module tb
   import msi_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] regAddr = 32'h0;
   logic [31:0] regWrData = 32'h0;
   logic regWr = 1'b0, regRd = 1'b0, crcFail = 1'b0, sqeSeen = 1'b0;
   logic link10M = 1'b1, halfDuplex = 1'b1, pauseFrameRcvd = 1'b0;
   logic deferred = 1'b0, txStart = 1'b0, collision = 1'b0;
   logic flowFrameRcvd = 1'b0, abortSeen = 1'b0, pauseSeen = 1'b0;
   logic [14:2] rxEvents = 13'h0;
   logic [2:0] rxFifoPackets = 3'h0;
   logic [31:0] regRdData;
   logic rxIrq, txHold, rxHold, rxDrop, txAbort, sendPauseFrame, sqeCheckEn;
   int badCount = 0;
   int checked = 0;
   int cycles = 0;

   always #10 sys_clk = ~sys_clk;

   msi_status u_dut (.sys_clk, .sys_rst, .regAddr, .regWrData, .regWr,
      .regRd, .regRdData, .crcFail, .rxEvents, .sqeSeen, .link10M,
      .halfDuplex, .pauseFrameRcvd, .deferred, .txStart, .collision,
      .rxFifoPackets, .flowFrameRcvd, .rxIrq, .txHold, .rxHold, .rxDrop,
      .txAbort, .sendPauseFrame, .sqeCheckEn);

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         badCount++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [31:0] a, d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, exp, input string nm);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 chk(nm, regRdData, exp);
   endtask

   task automatic waitN(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic hits(input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         collision <= 1'b1;
         @(posedge sys_clk);
         collision <= 1'b0;
      end
   endtask

   task automatic conclude;
      if (badCount == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one-cycle pulses are latched here; ceiling well above the run
   always @(posedge sys_clk)
   begin
      cycles++;
      if (txAbort === 1'b1)
         abortSeen <= 1'b1;
      if (sendPauseFrame === 1'b1)
         pauseSeen <= 1'b1;
      if (cycles == 3000)
      begin
         badCount++;
         conclude();
      end
   end

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(ADDR_INT_STATUS, 32'h0, "int status reset");
      rd(ADDR_GEN_STATUS, 32'h0, "gen status reset");
      rd(32'hb0003090, 32'h0, "unmapped");
      wr(ADDR_INT_ENABLE, 32'h2);
      @(posedge sys_clk);
      crcFail <= 1'b1;
      @(posedge sys_clk);
      crcFail <= 1'b0;
      rd(ADDR_INT_STATUS, 32'h3, "crc status");
      chk("irq summary off", 32'(rxIrq), 32'h0);
      wr(ADDR_INT_ENABLE, 32'h3);
      waitN(2);
      chk("irq on", 32'(rxIrq), 32'h1);
      wr(ADDR_INT_ENABLE, 32'h1);
      waitN(2);
      chk("irq bit masked", 32'(rxIrq), 32'h0);
      wr(ADDR_INT_ENABLE, 32'h7fff);
      @(posedge sys_clk);
      rxEvents <= 13'h1fff;
      @(posedge sys_clk);
      rxEvents <= 13'h0;
      rd(ADDR_INT_STATUS, 32'h7fff, "all events");
      wr(ADDR_INT_STATUS, 32'h7ffe);
      waitN(2);
      chk("irq cleared", 32'(rxIrq), 32'h0);
      rd(ADDR_INT_STATUS, 32'h0, "status cleared");
      wr(ADDR_COMMAND, 32'h20101);
      waitN(2);
      chk("sqe check en", 32'(sqeCheckEn), 32'h1);
      wr(ADDR_COMMAND, 32'h20000);
      @(posedge sys_clk);
      {sqeSeen, pauseFrameRcvd, deferred, collision} <= 4'hf;
      rxFifoPackets <= 3'h4;
      @(posedge sys_clk);
      {sqeSeen, pauseFrameRcvd, deferred, collision} <= 4'h0;
      rxFifoPackets <= 3'h0;
      hits(2);
      rd(ADDR_GEN_STATUS, 32'hf36, "gen flags");
      chk("holds", {29'h0, txHold, rxHold, rxDrop}, 32'h7);
      chk("no gen irq", 32'(rxIrq), 32'h0);
      wr(ADDR_GEN_STATUS, 32'hfffff008);
      rd(ADDR_GEN_STATUS, 32'hf36, "zero and reserved");
      wr(ADDR_GEN_STATUS, 32'hf36);
      rd(ADDR_GEN_STATUS, 32'h0, "w1c clear");
      @(posedge sys_clk);
      halfDuplex <= 1'b0;
      {sqeSeen, deferred, flowFrameRcvd} <= 3'h7;
      @(posedge sys_clk);
      {sqeSeen, deferred, flowFrameRcvd} <= 3'h0;
      rd(ADDR_GEN_STATUS, 32'h1, "full duplex");
      wr(ADDR_GEN_STATUS, 32'h1);
      @(posedge sys_clk);
      txStart <= 1'b1;
      @(posedge sys_clk);
      txStart <= 1'b0;
      hits(15);
      rd(ADDR_GEN_STATUS, 32'hf0, "count 15");
      hits(1);
      rd(ADDR_GEN_STATUS, 32'h0, "count wrap");
      waitN(1);
      chk("abort", 32'(abortSeen), 32'h1);
      @(posedge sys_clk);
      {halfDuplex, link10M, sqeSeen} <= 3'h5;
      @(posedge sys_clk);
      sqeSeen <= 1'b0;
      rd(ADDR_GEN_STATUS, 32'h0, "sqe on fast link");
      wr(ADDR_COMMAND, 32'h10000);
      rd(ADDR_GEN_STATUS, 32'h200, "pause flag");
      rd(ADDR_COMMAND, 32'h0, "pause bit reads 0");
      chk("pause pulse", 32'(pauseSeen), 32'h1);
      conclude();
   end
endmodule // tb
